// [common/bcfl_pkg.sv]
package bcfl_pkg;
  // primary and extended opcodes
  localparam logic [5:0] OPC_JUMP      = 6'h12;
  localparam logic [5:0] OPC_COND_JUMP = 6'h10;
  localparam logic [5:0] OPC_EXTENDED  = 6'h13;
  localparam logic [9:0] XO_TO_LINK    = 10'h010;
  localparam logic [9:0] XO_TO_COUNT   = 10'h210;
  localparam logic [9:0] XO_FLAG_AND   = 10'h101;
  localparam logic [9:0] XO_FLAG_OR    = 10'h1C1;
  localparam logic [9:0] XO_FLAG_XOR   = 10'h0C1;
  localparam logic [9:0] XO_FLAG_NAND  = 10'h0E1;
  localparam logic [9:0] XO_FLAG_NOR   = 10'h021;
  localparam logic [9:0] XO_FLAG_EQUIV = 10'h121;
  localparam logic [9:0] XO_FLAG_ANDN  = 10'h081;
  localparam logic [9:0] XO_FLAG_ORN   = 10'h1A1;
  localparam logic [9:0] XO_FIELD_COPY = 10'h000;
  // instruction bit positions, bit 0 = least significant
  localparam int POS_LINK_UPDATE = 0;
  localparam int POS_ABS_TARGET  = 1;
  localparam int POS_POLARITY    = 15;
  // positions inside the branch option field
  localparam int OPT_NO_COND  = 4;
  localparam int OPT_SENSE    = 3;
  localparam int OPT_NO_DEC   = 2;
  localparam int OPT_CNT_ZERO = 1;
  localparam int OPT_HINT     = 0;
  // register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_LINK   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_CTRL   = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_TARGET = 8'h1C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_LINK_PEND = 1;
  localparam int CTRL_COUNT_PEND = 2;
  localparam int ST_TAKEN = 0;
  localparam int ST_PREDICT = 1;
  localparam int ST_PRED_VALID = 2;
  localparam int ST_INVALID = 3;
  localparam int ST_BRANCH = 4;
  localparam int ST_DONE = 5;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] NEXT_INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;

  typedef enum {OP_JUMP, OP_COND, OP_TO_LINK, OP_TO_COUNT, OP_FLAG_LOGIC,
                OP_FIELD_COPY, OP_ILLEGAL} bcfl_op_e;

  // flag bit 0 is the most significant bit of the flags word
  function automatic logic flag_bit_at(input logic [31:0] flags, input logic [4:0] idx);
    return flags[5'd31 - idx];
  endfunction

  function automatic logic [3:0] flag_field_at(input logic [31:0] flags,
                                               input logic [2:0]  idx);
    return flags[5'd31 - {idx, 2'b00} -: 4];
  endfunction
endpackage

// [common/bcfl_cond_if.sv]
`timescale 1ns/1ps
interface bcfl_cond_if;
  logic [4:0]  opt;
  logic        cond_bit;
  logic [31:0] cnt;
  logic        sign_bit;
  logic        taken;
  logic        pred_taken;
  logic        opt_bad;
  logic        dec_cnt;
  logic [31:0] cnt_next;

  modport eval (input opt, cond_bit, cnt, sign_bit,
                output taken, pred_taken, opt_bad, dec_cnt, cnt_next);
  modport core (output opt, cond_bit, cnt, sign_bit,
                input taken, pred_taken, opt_bad, dec_cnt, cnt_next);
endinterface

// [hw/bcfl_cond_eval.sv]
`timescale 1ns/1ps
module bcfl_cond_eval
  import bcfl_pkg::*;
(
  bcfl_cond_if.eval ev
);
  logic always_br;
  logic hint;
  logic cnt_ok;
  logic cond_ok;

  // branch-always has no hint bit, zero stands in for it
  always_comb begin
    always_br = ev.opt[OPT_NO_COND] & ev.opt[OPT_NO_DEC]; // RQ2
    hint      = always_br ? 1'b0 : ev.opt[OPT_HINT]; // RQ1
  end

  // count handling: decrement first, then test the new value
  always_comb begin
    ev.dec_cnt  = ~ev.opt[OPT_NO_DEC]; // RQ8
    ev.cnt_next = ev.cnt - 32'h0000_0001; // RQ11
    if (ev.opt[OPT_NO_DEC]) begin
      cnt_ok = 1'b1; // RQ10
    end else if (ev.opt[OPT_CNT_ZERO]) begin
      cnt_ok = (ev.cnt_next == 32'h0000_0000); // RQ25
    end else begin
      cnt_ok = (ev.cnt_next != 32'h0000_0000); // RQ25
    end
  end

  // condition test, skipped when the option says so
  always_comb begin
    cond_ok  = ev.opt[OPT_NO_COND] | (ev.cond_bit == ev.opt[OPT_SENSE]); // RQ9
    ev.taken = cnt_ok & cond_ok; // RQ2
  end

  // static guess: negative displacement taken, hint inverts
  always_comb begin
    ev.pred_taken = ((ev.opt[OPT_NO_COND] & ev.opt[OPT_NO_DEC]) | ev.sign_bit) ^ hint; // RQ6
  end

  // must-be-zero option bits per encoding group
  always_comb begin
    if (always_br) begin
      ev.opt_bad = ev.opt[OPT_SENSE] | ev.opt[OPT_CNT_ZERO] | ev.opt[OPT_HINT]; // RQ12
    end else if (ev.opt[OPT_NO_COND]) begin
      ev.opt_bad = ev.opt[OPT_SENSE]; // RQ12
    end else if (ev.opt[OPT_NO_DEC]) begin
      ev.opt_bad = ev.opt[OPT_CNT_ZERO]; // RQ12
    end else begin
      ev.opt_bad = 1'b0;
    end
  end
endmodule

// [hw/bcfl_branch_unit.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - upper four option bits steer flags and count; lowest is the hint
// RQ2 - branch-always is unconditional and predicts with hint forced to zero
// RQ3 - hint clear: negative displacement predicts taken, others not; set inverts
// RQ4 - link or count targets predict only once that register is ready
// RQ5 - displacement sign drives prediction even for absolute targets
// RQ6 - predict taken when ((bo0 and bo2) or polarity) xor bo4 is one
// RQ7 - polarity is the displacement sign, zero for link and count forms
// RQ8 - options 0000y/0001y decrement count, branch on count test and false flag
// RQ9 - options 0100y/0101y decrement count, branch on count test and true flag
// RQ10 - flag-only options keep count, branch on false or true flag
// RQ11 - options 1z00y/1z01y decrement count, branch on count test only
// RQ12 - nonzero must-be-zero option bits make the instruction invalid
// RQ13 - five-bit select picks one of thirty-two condition flags
// RQ14 - relative jumps add instruction address, absolute jumps use immediate
// RQ15 - linking jumps write next sequential address to the link register
// RQ16 - flag and, or, xor combine two source flags into destination
// RQ17 - flag nand, nor, equiv store the inverted combination
// RQ18 - and-not and or-not use the inverse of the second source
// RQ19 - field copy moves one four-bit field, others untouched
// RQ20 - flag logic and field copy run on the integer execution path
// RQ21 - flag logic or field copy with link update is invalid
// RQ22 - low two bits of every computed target are cleared
// RQ23 - link write happens after target calculation, taken or not
// RQ24 - instruction bit 30 means absolute target, bit 31 link update
// RQ25 - option bit 3 clear: branch on nonzero count, set: on zero count
module bcfl_branch_unit
  import bcfl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata
);
  // architectural and software-visible state
  logic [31:0] instr;
  logic [31:0] cia;
  logic [31:0] loop_count_reg;
  logic [31:0] return_link_reg;
  logic [31:0] condition_flags_reg;
  logic        link_pend;
  logic        count_pend;
  logic        exec;
  logic        st_taken;
  logic        st_predict;
  logic        st_pred_valid;
  logic        st_invalid;
  logic        st_branch;
  logic        st_done;
  logic [31:0] target;

  // decode wires
  logic [5:0]  opcode;
  logic [9:0]  xo;
  logic        link_update_flag;
  logic        absolute_target_flag;
  logic [4:0]  branch_option_field;
  logic [4:0]  condition_select_field;
  logic [4:0]  flag_dst;
  logic [4:0]  flag_src_a;
  logic [4:0]  flag_src_b;
  logic [2:0]  field_dst;
  logic [2:0]  field_src;
  bcfl_op_e    op;
  logic [31:0] jump_imm;
  logic [31:0] cond_imm;
  logic [31:0] next_target;
  logic        is_branch;
  logic        next_invalid;
  logic        next_pred_valid;
  logic        flag_a;
  logic        flag_b;
  logic        flag_res;
  logic [31:0] next_flags;

  // bus wires
  logic        acc_ok;
  logic        bus_wr;
  logic        addr_ok;
  logic        addr_ro;
  logic [31:0] next_rdata;

  bcfl_cond_if cif ();

  bcfl_cond_eval u_eval (
    .ev (cif.eval)
  );

  // field extraction, bit 31 of the word is instruction bit 0
  always_comb begin
    opcode                 = instr[31:26];
    xo                     = instr[10:1];
    link_update_flag       = instr[POS_LINK_UPDATE]; // RQ24
    absolute_target_flag   = instr[POS_ABS_TARGET]; // RQ24
    branch_option_field    = instr[25:21]; // RQ1
    condition_select_field = instr[20:16]; // RQ13
    flag_dst               = instr[25:21];
    flag_src_a             = instr[20:16];
    flag_src_b             = instr[15:11];
    field_dst              = instr[25:23];
    field_src              = instr[20:18];
  end

  // instruction class from opcode and extended opcode
  always_comb begin
    op = OP_ILLEGAL;
    if (opcode == OPC_JUMP) begin
      op = OP_JUMP;
    end else if (opcode == OPC_COND_JUMP) begin
      op = OP_COND;
    end else if (opcode == OPC_EXTENDED) begin
      unique case (xo)
        XO_TO_LINK:    op = OP_TO_LINK;
        XO_TO_COUNT:   op = OP_TO_COUNT;
        XO_FLAG_AND,
        XO_FLAG_OR,
        XO_FLAG_XOR,
        XO_FLAG_NAND,
        XO_FLAG_NOR,
        XO_FLAG_EQUIV,
        XO_FLAG_ANDN,
        XO_FLAG_ORN:   op = OP_FLAG_LOGIC;
        XO_FIELD_COPY: op = OP_FIELD_COPY;
        default:       op = OP_ILLEGAL;
      endcase
    end
  end

  // feed the condition evaluator
  always_comb begin
    cif.opt      = branch_option_field;
    cif.cond_bit = flag_bit_at(condition_flags_reg, condition_select_field); // RQ13
    cif.cnt      = loop_count_reg;
    // link and count forms carry a reserved operand here, so no sign
    cif.sign_bit = (op == OP_COND) ? instr[POS_POLARITY] : 1'b0; // RQ7
  end

  // sign-extended immediates with the word offset appended
  always_comb begin
    jump_imm = {{6{instr[25]}}, instr[25:2], 2'b00};
    cond_imm = {{16{instr[15]}}, instr[15:2], 2'b00};
  end

  // target address, low two bits always dropped
  always_comb begin
    unique case (op)
      OP_JUMP: begin
        next_target = absolute_target_flag ? jump_imm : jump_imm + cia; // RQ14
      end
      OP_COND: begin
        next_target = absolute_target_flag ? cond_imm : cond_imm + cia; // RQ14
      end
      OP_TO_LINK: begin
        next_target = return_link_reg;
      end
      OP_TO_COUNT: begin
        next_target = loop_count_reg;
      end
      default: begin
        next_target = cia + NEXT_INSTR_STEP;
      end
    endcase
    next_target = next_target & WORD_ALIGN_MASK; // RQ22
  end

  // class flags, invalid forms and prediction readiness
  always_comb begin
    is_branch = (op == OP_JUMP) | (op == OP_COND) | (op == OP_TO_LINK) |
                (op == OP_TO_COUNT);
    next_invalid = (op == OP_ILLEGAL);
    if ((op == OP_COND) | (op == OP_TO_LINK) | (op == OP_TO_COUNT)) begin
      next_invalid = cif.opt_bad; // RQ12
    end
    if (((op == OP_FLAG_LOGIC) | (op == OP_FIELD_COPY)) & link_update_flag) begin
      next_invalid = 1'b1; // RQ21
    end
    // a register still being loaded leaves the guess unavailable
    next_pred_valid = ~((op == OP_TO_LINK) & link_pend) &
                      ~((op == OP_TO_COUNT) & count_pend); // RQ4
  end

  // flag logic, performed on the integer path rather than the branch path
  always_comb begin
    flag_a = flag_bit_at(condition_flags_reg, flag_src_a);
    flag_b = flag_bit_at(condition_flags_reg, flag_src_b);
    unique case (xo)
      XO_FLAG_AND:   flag_res = flag_a & flag_b; // RQ16
      XO_FLAG_OR:    flag_res = flag_a | flag_b; // RQ16
      XO_FLAG_XOR:   flag_res = flag_a ^ flag_b; // RQ16
      XO_FLAG_NAND:  flag_res = ~(flag_a & flag_b); // RQ17
      XO_FLAG_NOR:   flag_res = ~(flag_a | flag_b); // RQ17
      XO_FLAG_EQUIV: flag_res = ~(flag_a ^ flag_b); // RQ17
      XO_FLAG_ANDN:  flag_res = flag_a & ~flag_b; // RQ18
      XO_FLAG_ORN:   flag_res = flag_a | ~flag_b; // RQ18
      default:       flag_res = 1'b0;
    endcase
  end

  // new flags word: one bit for logic ops, one field for the copy
  always_comb begin
    next_flags = condition_flags_reg;
    if (op == OP_FLAG_LOGIC) begin
      next_flags[5'd31 - flag_dst] = flag_res; // RQ20
    end else if (op == OP_FIELD_COPY) begin
      next_flags[5'd31 - {field_dst, 2'b00} -: 4] =
        flag_field_at(condition_flags_reg, field_src); // RQ19
    end
  end

  // bus decode
  always_comb begin
    addr_ok = (paddr == OFS_INSTR) | (paddr == OFS_ADDR) | (paddr == OFS_COUNT) |
              (paddr == OFS_LINK) | (paddr == OFS_FLAGS) | (paddr == OFS_CTRL) |
              (paddr == OFS_STATUS) | (paddr == OFS_TARGET);
    addr_ro = (paddr == OFS_STATUS) | (paddr == OFS_TARGET);
    // reads wait while an execution step is pending, so no stale word escapes
    acc_ok  = psel & ~pready & ~exec;
    bus_wr  = psel & penable & pready & pwrite & ~pslverr;
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    unique case (paddr)
      OFS_INSTR:  next_rdata = instr;
      OFS_ADDR:   next_rdata = cia;
      OFS_COUNT:  next_rdata = loop_count_reg;
      OFS_LINK:   next_rdata = return_link_reg;
      OFS_FLAGS:  next_rdata = condition_flags_reg;
      OFS_CTRL:   next_rdata = {29'h0, count_pend, link_pend, 1'b0};
      OFS_STATUS: next_rdata = {26'h0, st_done, st_branch, st_invalid,
                                st_pred_valid, st_predict, st_taken};
      OFS_TARGET: next_rdata = target;
      default:    next_rdata = RST_WORD;
    endcase
  end

  // bus answer: one wait-free access phase unless an execution is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
    end else begin
      // error and data stand only beside ready, so a refused access cannot linger
      pready  <= acc_ok;
      pslverr <= acc_ok & (~addr_ok | (pwrite & addr_ro));
      prdata  <= (acc_ok & ~pwrite) ? next_rdata : RST_WORD;
    end
  end

  // instruction word and its address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= RST_WORD;
      cia   <= RST_WORD;
    end else if (bus_wr) begin
      if (paddr == OFS_INSTR) begin
        instr <= pwdata;
      end
      if (paddr == OFS_ADDR) begin
        cia <= pwdata;
      end
    end
  end

  // control: go starts one execution step, pending bits gate prediction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec       <= 1'b0;
      link_pend  <= 1'b0;
      count_pend <= 1'b0;
    end else begin
      exec <= bus_wr & (paddr == OFS_CTRL) & pwdata[CTRL_GO];
      if (bus_wr & (paddr == OFS_CTRL)) begin
        link_pend  <= pwdata[CTRL_LINK_PEND];
        count_pend <= pwdata[CTRL_COUNT_PEND];
      end
    end
  end

  // count register: software load or decrement by a valid branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_count_reg <= RST_WORD;
    end else if (exec) begin
      if (!next_invalid & (op != OP_JUMP) & is_branch & cif.dec_cnt) begin
        loop_count_reg <= cif.cnt_next; // RQ8
      end
    end else if (bus_wr & (paddr == OFS_COUNT)) begin
      loop_count_reg <= pwdata;
    end
  end

  // link register: written after the target used the old value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_link_reg <= RST_WORD;
    end else if (exec) begin
      if (!next_invalid & is_branch & link_update_flag) begin
        return_link_reg <= cia + NEXT_INSTR_STEP; // RQ15 RQ23
      end
    end else if (bus_wr & (paddr == OFS_LINK)) begin
      return_link_reg <= pwdata;
    end
  end

  // condition flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_flags_reg <= RST_WORD;
    end else if (exec) begin
      if (!next_invalid) begin
        condition_flags_reg <= next_flags; // RQ20
      end
    end else if (bus_wr & (paddr == OFS_FLAGS)) begin
      condition_flags_reg <= pwdata;
    end
  end

  // outcome of the last execution step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_taken      <= 1'b0;
      st_predict    <= 1'b0;
      st_pred_valid <= 1'b0;
      st_invalid    <= 1'b0;
      st_branch     <= 1'b0;
      st_done       <= 1'b0;
      target        <= RST_WORD;
    end else if (exec) begin
      st_done    <= 1'b1;
      st_invalid <= next_invalid;
      st_branch  <= is_branch & ~next_invalid;
      // plain jumps are always taken; invalid forms never branch
      if (next_invalid | !is_branch) begin
        st_taken      <= 1'b0;
        st_predict    <= 1'b0;
        st_pred_valid <= 1'b0;
      end else if (op == OP_JUMP) begin
        st_taken      <= 1'b1; // RQ14
        st_predict    <= 1'b1;
        st_pred_valid <= 1'b1;
      end else begin
        st_taken      <= cif.taken; // RQ10 RQ11
        st_predict    <= cif.pred_taken & next_pred_valid; // RQ3 RQ5
        st_pred_valid <= next_pred_valid; // RQ4
      end
      target <= next_target; // RQ22
    end else if (bus_wr & (paddr == OFS_CTRL) & pwdata[CTRL_GO]) begin
      st_done <= 1'b0;
    end
  end
endmodule

// [verification/bcfl_branch_unit_checker.sv]
`timescale 1ns/1ps
module bcfl_branch_checker
  import bcfl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completing access phase, shared by every data relation below
  logic acc;
  assign acc = psel && penable && pready;

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");

  property p_answer_bound;
    psel && !penable |-> ##[1:2] pready;
  endproperty
  a_answer_bound: assert property (p_answer_bound) else $error("no answer within two cycles");

  property p_err_with_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error outside access");

  property p_unmapped;
    acc && (paddr > OFS_TARGET || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_ro_write;
    acc && pwrite && (paddr == OFS_STATUS || paddr == OFS_TARGET) |-> pslverr;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");

  property p_target_align;
    acc && !pwrite && paddr == OFS_TARGET |-> prdata[1:0] == 2'h0;
  endproperty
  a_target_align: assert property (p_target_align) else $error("target not aligned");

  property p_invalid_quiet;
    acc && !pwrite && paddr == OFS_STATUS && prdata[ST_INVALID]
      |-> !prdata[ST_TAKEN] && !prdata[ST_PREDICT] && !prdata[ST_BRANCH];
  endproperty
  a_invalid_quiet: assert property (p_invalid_quiet) else $error("invalid form acted");

  property p_pred_gated;
    acc && !pwrite && paddr == OFS_STATUS && !prdata[ST_PRED_VALID] |-> !prdata[ST_PREDICT];
  endproperty
  a_pred_gated: assert property (p_pred_gated) else $error("prediction before ready");

  property p_go_reads_zero;
    acc && !pwrite && paddr == OFS_CTRL |-> !prdata[CTRL_GO];
  endproperty
  a_go_reads_zero: assert property (p_go_reads_zero) else $error("go bit read back");

  property p_write_quiet;
    acc && pwrite |-> prdata == 32'h0;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("read data on a write");
endmodule

bind bcfl_branch_unit bcfl_branch_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .prdata);

// [verification/bcfl_host_model.sv]
`timescale 1ns/1ps
module bcfl_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  logic [31:0] rd_q;
  logic        err_q;

  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer, entered just after a rising edge; one idle cycle after it
  // so no signal is assigned twice in a time step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here; the bench's hang guard ends a lost transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// [verification/branch_condition_flag_logic_bench.sv]
`timescale 1ns/1ps
module branch_condition_flag_logic_bench
  import bcfl_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [31:0] st;
  logic [31:0] tg;
  logic [31:0] cn;
  logic [31:0] ln;
  logic [31:0] fl;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;

  bcfl_branch_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata);
  bcfl_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    u_host.xfer(1'b0, a, 32'h0);
    v = u_host.rd_q;
  endtask

  // load operands, fire one step, collect every result register
  task automatic step(input logic [31:0] ins, input logic [31:0] ad, input logic [31:0] c,
                      input logic [31:0] l, input logic [31:0] f, input logic [2:0] ctl);
    u_host.xfer(1'b1, OFS_INSTR, ins);
    u_host.xfer(1'b1, OFS_ADDR, ad);
    u_host.xfer(1'b1, OFS_COUNT, c);
    u_host.xfer(1'b1, OFS_LINK, l);
    u_host.xfer(1'b1, OFS_FLAGS, f);
    u_host.xfer(1'b1, OFS_CTRL, {29'h0, ctl});
    rd(OFS_STATUS, st);
    rd(OFS_TARGET, tg);
    rd(OFS_COUNT, cn);
    rd(OFS_LINK, ln);
    rd(OFS_FLAGS, fl);
  endtask

  // reset values, an unmapped read and a write to a read-only place
  task automatic t_reset;
    logic [31:0] v;
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), v);
      chk(v, 32'h0);
    end
    u_host.xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, u_host.err_q}, 32'h1);
    u_host.xfer(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    chk({31'h0, u_host.err_q}, 32'h1);
    rd(OFS_STATUS, v);
    chk(v, 32'h0);
  endtask

  // all four plain jump forms, negative immediate
  task automatic t_jumps;
    for (int k = 0; k < 4; k++) begin
      step({OPC_JUMP, 24'hFFFFFE, k[1], k[0]}, 32'h1000, 32'h0, 32'h5550, 32'h0, 3'h1);
      chk(tg, k[1] ? 32'hFFFF_FFF8 : 32'h0000_0FF8);
      chk(ln, k[0] ? 32'h0000_1004 : 32'h0000_5550);
      chk({30'h0, st[ST_PREDICT], st[ST_TAKEN]}, 32'h3);
    end
  endtask

  // every option code, both count outcomes, both flag senses, all select values
  task automatic t_cond;
    logic [4:0]  b;
    logic        cnd;
    logic        s;
    logic        bad;
    logic        tk;
    logic        pr;
    logic [31:0] c;
    logic [31:0] nc;
    for (int i = 0; i < 64; i++) begin
      b = i[4:0];
      cnd = i[5];
      s = i[0] ^ i[5];
      c = cnd ? 32'h1 : 32'h5;
      bad = (b[4] & b[3]) | (~b[4] & b[2] & b[1]) | (b[4] & b[2] & (b[1] | b[0]));
      nc = (b[2] | bad) ? c : c - 32'h1;
      tk = (b[2] | ((nc == 32'h0) == b[1])) & (b[4] | (cnd == b[3]));
      pr = ((b[4] & b[2]) | s) ^ (b[0] & ~(b[4] & b[2]));
      step({OPC_COND_JUMP, b, b, s, 13'h0010, i[2], i[1]}, 32'h2000, c, 32'h0,
           cnd ? 32'h1 << (5'd31 - b) : ~(32'h1 << (5'd31 - b)), 3'h1);
      chk({29'h0, st[ST_INVALID], st[ST_PREDICT], st[ST_TAKEN]},
          {29'h0, bad, pr & ~bad, tk & ~bad});
      chk(tg, i[2] ? (s ? 32'hFFFF_8040 : 32'h40) : (s ? 32'hFFFF_A040 : 32'h2040));
      chk(cn, nc);
      chk(ln, (i[1] && !bad) ? 32'h2004 : 32'h0);
    end
  endtask

  // register-target forms, reserved bit set, target register pending or ready
  task automatic t_regs;
    for (int k = 0; k < 8; k++) begin
      step({OPC_EXTENDED, 4'h2, k[0], 5'h0, 5'h10, k[1] ? XO_TO_COUNT : XO_TO_LINK, 1'b0},
           32'h3000, 32'h4007, 32'h2003, 32'h0, {k[1] & k[2], ~k[1] & k[2], 1'b1});
      chk({29'h0, st[ST_PRED_VALID:ST_TAKEN]}, {29'h0, ~k[2], k[0] & ~k[2], 1'b1});
      chk(tg, k[1] ? 32'h0000_4004 : 32'h0000_2000);
    end
  endtask

  // flag logic truth tables, linked form refused, field copy
  task automatic t_flags;
    logic [9:0]  xo [8] = '{XO_FLAG_AND, XO_FLAG_OR, XO_FLAG_XOR, XO_FLAG_NAND,
                            XO_FLAG_NOR, XO_FLAG_EQUIV, XO_FLAG_ANDN, XO_FLAG_ORN};
    logic [3:0]  tt [8] = '{4'h8, 4'hE, 4'h6, 4'h7, 4'h1, 4'h9, 4'h4, 4'hD};
    logic [31:0] f;
    for (int i = 0; i < 32; i++) begin
      f = 32'h0F0F_0F0C;
      f[28] = i[1];
      f[14] = i[0];
      step({OPC_EXTENDED, 5'd30, 5'd3, 5'd17, xo[i[4:2]], 1'b0}, 32'h0, 32'h0, 32'h0, f, 3'h1);
      f[1] = tt[i[4:2]][i[1:0]];
      chk(fl, f);
    end
    step({OPC_EXTENDED, 5'd30, 5'd3, 5'd17, XO_FLAG_OR, 1'b1}, 32'h0, 32'h0, 32'h0,
         32'hF000_0000, 3'h1);
    chk(fl, 32'hF000_0000);
    chk({31'h0, st[ST_INVALID]}, 32'h1);
    step({OPC_EXTENDED, 3'd6, 2'h0, 3'd1, 7'h0, XO_FIELD_COPY, 1'b0}, 32'h0, 32'h0, 32'h0,
         32'h1234_5678, 3'h1);
    chk(fl, 32'h1234_5628);
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 3700 cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish;
    end
  end

  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_jumps;
    t_cond;
    t_regs;
    t_flags;
    tally_and_finish;
  end
endmodule
